// *** hwtc_top.sv ***
// hardware-mode transmit clock source and internal termination control
// Function
// - transmit pll always referenced to tx_clock_in
// - select pins decode 00/01/10/11 to four sources
// - pll clock pin equals selected transmit clock
// - termination follows selected modes automatically
// - transmit termination disable switches termination off
// - receive termination disable switches termination off
// - e1 select: 0 gives 75, 1 gives 120
// - one e1 select serves both directions
// - hardware mode repurposes port pins, fixes rest
// - interrupt pin doubles as jitter clock select
// - chip select pin doubles as remote loopback
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hwtc_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // mode strap
    input wire logic [1:0] bus_if_sel_in,
    // clock sources
    input wire logic tx_clock_in,
    input wire logic tx_pll_clk_in,
    input wire logic mclk_scaled_in,
    input wire logic rx_clk_in,
    // hardware mode control pins
    input wire logic tx_clk_src_sel_lo_in,
    input wire logic tx_clk_src_sel_hi_in,
    input wire logic tx_term_disable_in,
    input wire logic rx_term_disable_in,
    input wire logic e1_term_impedance_sel_in,
    input wire logic [3:0] tx_mode_select_pins_in,
    input wire logic [3:0] rx_mode_select_pins_in,
    // shared pins and the interrupt request for the irq pin
    input wire logic irq_n_pin_in,
    input wire logic cs_n_pin_in,
    input wire logic irq_req_in,
    // clock outputs
    output logic tx_clk_out,
    output logic pll_clk_out,
    output logic pll_ref_out,
    // termination
    output hwtc_pkg::hwtc_term_t tx_term_out,
    output hwtc_pkg::hwtc_term_t rx_term_out,
    // mode and shared pin functions
    output logic hw_mode_out,
    output logic irq_n_pin_out,
    output logic irq_n_pin_oe_out,
    output logic jitter_att_clk_sel0_out,
    output logic remote_loopback_en_out,
    output logic port_cs_n_out
);
    localparam int unsigned NSYNC = 21;

    logic [NSYNC-1:0] async_w;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [1:0] bus_if_sel_s;
    logic tx_clock_s;
    logic tx_pll_s;
    logic mclk_s;
    logic rx_clk_s;
    logic sel_lo_s;
    logic sel_hi_s;
    logic tx_dis_s;
    logic rx_dis_s;
    logic e1_s;
    logic [3:0] tx_mode_s;
    logic [3:0] rx_mode_s;
    logic irq_pin_s;
    logic cs_pin_s;

    logic hw_mode_r;
    logic [31:0] ctrl_r;
    logic [1:0] sel_eff;
    logic [1:0] active_sel;
    logic switching;
    logic [31:0] status_w;
    logic setup_w;
    logic access_w;
    logic tx_clk_w;
    logic pll_clk_w;

    hwtc_term_if tx_if ();
    hwtc_term_if rx_if ();

    // every pin and foreign clock is sampled twice before use
    assign async_w = {bus_if_sel_in, tx_clock_in, tx_pll_clk_in, mclk_scaled_in, rx_clk_in,
                      tx_clk_src_sel_lo_in, tx_clk_src_sel_hi_in, tx_term_disable_in,
                      rx_term_disable_in, e1_term_impedance_sel_in, tx_mode_select_pins_in,
                      rx_mode_select_pins_in, irq_n_pin_in, cs_n_pin_in};

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= async_w[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign {bus_if_sel_s, tx_clock_s, tx_pll_s, mclk_s, rx_clk_s, sel_lo_s, sel_hi_s, tx_dis_s,
            rx_dis_s, e1_s, tx_mode_s, rx_mode_s, irq_pin_s, cs_pin_s} = sync_r;

    // mode is followed continuously; a strap changing on the fly simply re-selects
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hw_mode_r <= 1'b0;
        end else begin
            hw_mode_r <= (bus_if_sel_s == hwtc_pkg::HW_MODE_CODE);
        end
    end

    // source selection: pins in hardware mode, control register otherwise
    assign sel_eff = hw_mode_r ? {sel_hi_s, sel_lo_s}
                               : ctrl_r[hwtc_pkg::CTRL_SRC_LSB +: 2];

    hwtc_clk_mux u_mux (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .src_in({rx_clk_s, mclk_s, tx_pll_s, tx_clock_s}),
        .sel_in(sel_eff),
        .clk_out(tx_clk_w),
        .pll_out(pll_clk_w),
        .active_sel_out(active_sel),
        .switching_out(switching)
    );

    assign tx_clk_out = tx_clk_w;
    assign pll_clk_out = pll_clk_w;

    // the pll reference has no selector at all
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_ref_out <= 1'b0;
        end else begin
            pll_ref_out <= tx_clock_s;
        end
    end

    // termination inputs; one impedance select feeds both directions
    assign tx_if.mode = hw_mode_r ? tx_mode_s : ctrl_r[hwtc_pkg::CTRL_TX_MODE_LSB +: 4];
    assign rx_if.mode = hw_mode_r ? rx_mode_s : ctrl_r[hwtc_pkg::CTRL_RX_MODE_LSB +: 4];
    assign tx_if.dis = hw_mode_r ? tx_dis_s : ctrl_r[hwtc_pkg::CTRL_TX_DIS];
    assign rx_if.dis = hw_mode_r ? rx_dis_s : ctrl_r[hwtc_pkg::CTRL_RX_DIS];
    assign tx_if.e1_sel = hw_mode_r ? e1_s : ctrl_r[hwtc_pkg::CTRL_E1_SEL];
    assign rx_if.e1_sel = hw_mode_r ? e1_s : ctrl_r[hwtc_pkg::CTRL_E1_SEL];

    hwtc_term_dec u_tx_term (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .t(tx_if)
    );

    hwtc_term_dec u_rx_term (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .t(rx_if)
    );

    assign tx_term_out = tx_if.term;
    assign rx_term_out = rx_if.term;

    // shared pins: port functions outside hardware mode, direct controls inside it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hw_mode_out <= 1'b0;
            irq_n_pin_out <= 1'b0;
            irq_n_pin_oe_out <= 1'b0;
            jitter_att_clk_sel0_out <= 1'b0;
            remote_loopback_en_out <= 1'b0;
            port_cs_n_out <= 1'b1;
        end else begin
            hw_mode_out <= hw_mode_r;
            // open drain: only ever pulls low
            irq_n_pin_out <= 1'b0;
            irq_n_pin_oe_out <= !hw_mode_r && irq_req_in;
            jitter_att_clk_sel0_out <= hw_mode_r && irq_pin_s;
            remote_loopback_en_out <= hw_mode_r && cs_pin_s;
            port_cs_n_out <= hw_mode_r ? 1'b1 : cs_pin_s;
        end
    end

    // apb slave, zero wait states
    assign setup_w = psel_in && !penable_in;
    assign access_w = psel_in && penable_in && pready_out;

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[hwtc_pkg::STAT_HW_MODE] = hw_mode_r;
        status_w[hwtc_pkg::STAT_SRC_LSB +: 2] = active_sel;
        status_w[hwtc_pkg::STAT_SWITCHING] = switching;
        status_w[hwtc_pkg::STAT_TX_TERM_LSB +: 3] = tx_if.term;
        status_w[hwtc_pkg::STAT_RX_TERM_LSB +: 3] = rx_if.term;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= setup_w;
            if (setup_w) begin
                pslverr_out <= !((paddr_in == hwtc_pkg::CTRL_ADDR) ||
                                 (paddr_in == hwtc_pkg::STATUS_ADDR && !pwrite_in));
                if (pwrite_in) begin
                    prdata_out <= 32'h0000_0000;
                end else if (paddr_in == hwtc_pkg::CTRL_ADDR) begin
                    prdata_out <= ctrl_r;
                end else if (paddr_in == hwtc_pkg::STATUS_ADDR) begin
                    prdata_out <= status_w;
                end else begin
                    prdata_out <= 32'h0000_0000;
                end
            end
        end
    end

    // control is only consulted outside hardware mode, where it stands in for the pins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= hwtc_pkg::CTRL_RST;
        end else if (access_w && pwrite_in && paddr_in == hwtc_pkg::CTRL_ADDR) begin
            ctrl_r <= pwdata_in & hwtc_pkg::CTRL_MASK;
        end
    end

    property p_pll_ref;
        @(posedge clk_in) disable iff (rst_in)
        !$past(rst_in, 3) |-> pll_ref_out == $past(tx_clock_in, 3);
    endproperty
    a_pll_ref: assert property (p_pll_ref) else $error("pll reference not from tx clock pin");

    property p_src_decode;
        @(posedge clk_in) disable iff (rst_in)
        (hw_mode_r && $past(hw_mode_r) && !u_mux.switching_out && !switching && u_mux.state_r == 0)
            |-> active_sel == $past({sel_hi_s, sel_lo_s});
    endproperty
    a_src_decode: assert property (p_src_decode) else $error("active source differs from select pins");

    property p_pll_same;
        @(posedge clk_in) disable iff (rst_in)
        pll_clk_out == tx_clk_out;
    endproperty
    a_pll_same: assert property (p_pll_same) else $error("pll clock pin differs from transmit clock");

    property p_auto_term;
        @(posedge clk_in) disable iff (rst_in)
        $past(hw_mode_r && !rx_dis_s && rx_mode_s == 4'h0) |-> rx_term_out == hwtc_pkg::TERM_100;
    endproperty
    a_auto_term: assert property (p_auto_term) else $error("t1 receive termination not applied");

    property p_tx_dis;
        @(posedge clk_in) disable iff (rst_in)
        $past(hw_mode_r && tx_dis_s) |-> tx_term_out == hwtc_pkg::TERM_OFF;
    endproperty
    a_tx_dis: assert property (p_tx_dis) else $error("transmit termination not disabled");

    property p_rx_dis;
        @(posedge clk_in) disable iff (rst_in)
        $past(hw_mode_r && rx_dis_s) |-> rx_term_out == hwtc_pkg::TERM_OFF;
    endproperty
    a_rx_dis: assert property (p_rx_dis) else $error("receive termination not disabled");

    property p_e1_imp;
        @(posedge clk_in) disable iff (rst_in)
        $past(hw_mode_r && !tx_dis_s && tx_mode_s[3:2] == hwtc_pkg::GRP_E1)
            |-> tx_term_out == ($past(e1_s) ? hwtc_pkg::TERM_120 : hwtc_pkg::TERM_75);
    endproperty
    a_e1_imp: assert property (p_e1_imp) else $error("e1 impedance select not honoured");

    property p_e1_both;
        @(posedge clk_in) disable iff (rst_in)
        $past(hw_mode_r && !tx_dis_s && !rx_dis_s && tx_mode_s[3:2] == hwtc_pkg::GRP_E1
              && rx_mode_s[3:2] == hwtc_pkg::GRP_E1) |-> tx_term_out == rx_term_out;
    endproperty
    a_e1_both: assert property (p_e1_both) else $error("e1 terminations differ between directions");

    property p_fixed;
        @(posedge clk_in) disable iff (rst_in)
        $past(hw_mode_r) |-> port_cs_n_out && !irq_n_pin_oe_out;
    endproperty
    a_fixed: assert property (p_fixed) else $error("port functions active in hardware mode");

    property p_irq;
        @(posedge clk_in) disable iff (rst_in)
        !$past(rst_in) && $past(!hw_mode_r && irq_req_in)
            |-> irq_n_pin_oe_out && !irq_n_pin_out && !jitter_att_clk_sel0_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not driven low in port mode");

    property p_rlb;
        @(posedge clk_in) disable iff (rst_in)
        !$past(rst_in) && $past(!hw_mode_r) |-> !remote_loopback_en_out && port_cs_n_out == $past(cs_pin_s);
    endproperty
    a_rlb: assert property (p_rlb) else $error("chip select misrouted in port mode");
endmodule : hwtc_top
`default_nettype wire

// *** hwtc_pkg.sv ***
// shared constants and types for the hardware-mode transmit clock and termination block
package hwtc_pkg;
    // apb map
    localparam int unsigned APB_AW = 12;
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_1FFF;
    // control fields
    localparam int unsigned CTRL_SRC_LSB = 0;
    localparam int unsigned CTRL_TX_DIS = 2;
    localparam int unsigned CTRL_RX_DIS = 3;
    localparam int unsigned CTRL_E1_SEL = 4;
    localparam int unsigned CTRL_RX_MODE_LSB = 5;
    localparam int unsigned CTRL_TX_MODE_LSB = 9;
    // status fields
    localparam int unsigned STAT_HW_MODE = 0;
    localparam int unsigned STAT_SRC_LSB = 1;
    localparam int unsigned STAT_SWITCHING = 3;
    localparam int unsigned STAT_TX_TERM_LSB = 4;
    localparam int unsigned STAT_RX_TERM_LSB = 7;
    // bus interface select code that means hardware controller mode
    localparam logic [1:0] HW_MODE_CODE = 2'h3;
    // transmit clock sources, index into the source vector
    localparam logic [1:0] SRC_TX_CLK = 2'h0;
    localparam logic [1:0] SRC_TX_PLL = 2'h1;
    localparam logic [1:0] SRC_MCLK = 2'h2;
    localparam logic [1:0] SRC_RX_CLK = 2'h3;
    // operating mode groups, upper two mode bits
    localparam logic [1:0] GRP_T1J1 = 2'h0;
    localparam logic [1:0] GRP_E1 = 2'h1;
    localparam logic [1:0] GRP_SYNC = 2'h2;
    localparam logic [1:0] GRP_RSVD = 2'h3;
    localparam logic [3:0] MODE_E1_SYNC = 4'h8;
    localparam logic [3:0] MODE_6312 = 4'hB;
    // termination settings
    typedef enum logic [2:0] {
        TERM_OFF,
        TERM_75,
        TERM_100,
        TERM_110,
        TERM_120
    } hwtc_term_t;
endpackage : hwtc_pkg

// *** hwtc_term_if.sv ***
// termination request and result between top and decoder
`timescale 1ns/1ps
`default_nettype none
interface hwtc_term_if;
    logic [3:0] mode;
    logic dis;
    logic e1_sel;
    hwtc_pkg::hwtc_term_t term;
    modport dec (input mode, input dis, input e1_sel, output term);
    modport user (output mode, output dis, output e1_sel, input term);
endinterface : hwtc_term_if
`default_nettype wire

// *** hwtc_term_dec.sv ***
// decodes an operating mode into an internal termination setting
`timescale 1ns/1ps
`default_nettype none
module hwtc_term_dec (
    input wire logic clk_in,
    input wire logic rst_in,
    hwtc_term_if.dec t
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            t.term <= hwtc_pkg::TERM_OFF;
        end else if (t.dis) begin
            t.term <= hwtc_pkg::TERM_OFF;
        end else begin
            unique case (t.mode[3:2])
                hwtc_pkg::GRP_T1J1: begin
                    t.term <= t.mode[1] ? hwtc_pkg::TERM_110 : hwtc_pkg::TERM_100;
                end
                hwtc_pkg::GRP_E1: begin
                    t.term <= t.e1_sel ? hwtc_pkg::TERM_120 : hwtc_pkg::TERM_75;
                end
                hwtc_pkg::GRP_SYNC: begin
                    if (t.mode == hwtc_pkg::MODE_E1_SYNC) begin
                        t.term <= t.e1_sel ? hwtc_pkg::TERM_120 : hwtc_pkg::TERM_75;
                    end else if (t.mode == hwtc_pkg::MODE_6312) begin
                        t.term <= hwtc_pkg::TERM_75;
                    end else begin
                        t.term <= hwtc_pkg::TERM_110;
                    end
                end
                hwtc_pkg::GRP_RSVD: begin
                    // reserved modes leave the line unterminated
                    t.term <= hwtc_pkg::TERM_OFF;
                end
            endcase
        end
    end
endmodule : hwtc_term_dec
`default_nettype wire

// *** hwtc_clk_mux.sv ***
// glitch-free four-way selector of sampled clock sources
`timescale 1ns/1ps
`default_nettype none
module hwtc_clk_mux (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] src_in,
    input wire logic [1:0] sel_in,
    output logic clk_out,
    output logic pll_out,
    output logic [1:0] active_sel_out,
    output logic switching_out
);
    typedef enum logic [1:0] {
        HWTC_RUN,
        HWTC_WAIT_OLD_LOW,
        HWTC_WAIT_NEW_LOW
    } hwtc_mux_state_t;

    hwtc_mux_state_t state_r;
    logic [1:0] target_r;
    logic target_prev_r;
    logic out_nxt;

    // output stays high only for whole pulses of one source; between sources it parks low
    always_comb begin
        out_nxt = (state_r == HWTC_WAIT_NEW_LOW) ? 1'b0 : src_in[active_sel_out];
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= HWTC_RUN;
            target_r <= hwtc_pkg::SRC_TX_CLK;
            active_sel_out <= hwtc_pkg::SRC_TX_CLK;
        end else begin
            unique case (state_r)
                HWTC_RUN: begin
                    if (sel_in != active_sel_out) begin
                        target_r <= sel_in;
                        state_r <= HWTC_WAIT_OLD_LOW;
                    end
                end
                HWTC_WAIT_OLD_LOW: begin
                    if (!src_in[active_sel_out]) begin
                        state_r <= HWTC_WAIT_NEW_LOW;
                    end
                end
                HWTC_WAIT_NEW_LOW: begin
                    // hand over only at a falling edge of the new source, so the parked low
                    // lasts at least one half period of it; a stopped new source stalls the switch
                    if (target_prev_r && !src_in[target_r]) begin
                        active_sel_out <= target_r;
                        state_r <= HWTC_RUN;
                    end
                end
            endcase
        end
    end

    // previous level of the incoming source, for the falling-edge handover
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            target_prev_r <= 1'b0;
        end else begin
            target_prev_r <= src_in[target_r];
        end
    end

    // both pins share one next value so they can never differ
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_out <= 1'b0;
            pll_out <= 1'b0;
            switching_out <= 1'b0;
        end else begin
            clk_out <= out_nxt;
            pll_out <= out_nxt;
            switching_out <= (state_r != HWTC_RUN);
        end
    end

    property p_no_runt;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == HWTC_WAIT_NEW_LOW) |=> !clk_out;
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("clock output not parked low while switching");
endmodule : hwtc_clk_mux
`default_nettype wire

// *** hwtc_src_model.sv ***
// board-side model of the four slow transmit clock sources
`timescale 1ns/1ps
`default_nettype none
module hwtc_src_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // sources: tx clock, tx pll, scaled master clock, recovered clock
    output logic [3:0] src_out
);
    // periods 8, 12, 16, 24 cycles so each source shows its own edge count
    localparam int HALF [4] = '{4, 6, 8, 12};
    for (genvar g = 0; g < 4; g++) begin : g_src
        logic [4:0] cnt_r;
        logic clk_r;
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                cnt_r <= 5'h00;
                clk_r <= 1'b0;
            end else if (cnt_r == 5'(HALF[g] - 1)) begin
                cnt_r <= 5'h00;
                clk_r <= ~clk_r;
            end else begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
        assign src_out[g] = clk_r;
    end
endmodule : hwtc_src_model
`default_nettype wire

// *** hwtc_top_tb.sv ***
// self-checking testbench for the transmit clock and termination block
`timescale 1ns/1ps
`default_nettype none
module hwtc_top_tb;
    logic clk_in, rst_in, psel_in, penable_in, pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd, d;
    logic pready_out, pslverr_out, err;
    logic [1:0] bus_if_sel_in;
    logic tx_clk_src_sel_lo_in, tx_clk_src_sel_hi_in, tx_term_disable_in, rx_term_disable_in;
    logic e1_term_impedance_sel_in, irq_n_pin_in, cs_n_pin_in, irq_req_in;
    logic [3:0] tx_mode_select_pins_in, rx_mode_select_pins_in, src;
    logic tx_clk_out, pll_clk_out, pll_ref_out, hw_mode_out, irq_n_pin_out, irq_n_pin_oe_out;
    logic jitter_att_clk_sel0_out, remote_loopback_en_out, port_cs_n_out, prev, last;
    hwtc_pkg::hwtc_term_t tx_term_out, rx_term_out;
    int num_errors = 0;
    int checks_done = 0;
    int seed, n, runlen, since;
    logic [2:0] hist;

    hwtc_src_model hwtc_src_model_i (.clk_in, .rst_in, .src_out(src));
    hwtc_top hwtc_top_i (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .bus_if_sel_in, .tx_clock_in(src[0]),
        .tx_pll_clk_in(src[1]), .mclk_scaled_in(src[2]), .rx_clk_in(src[3]), .tx_clk_src_sel_lo_in,
        .tx_clk_src_sel_hi_in, .tx_term_disable_in, .rx_term_disable_in, .e1_term_impedance_sel_in,
        .tx_mode_select_pins_in, .rx_mode_select_pins_in, .irq_n_pin_in, .cs_n_pin_in, .irq_req_in,
        .tx_clk_out, .pll_clk_out, .pll_ref_out, .tx_term_out, .rx_term_out, .hw_mode_out,
        .irq_n_pin_out, .irq_n_pin_oe_out, .jitter_att_clk_sel0_out, .remote_loopback_en_out,
        .port_cs_n_out);

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [31:0] exp_term(input logic [3:0] m, input logic dis, input logic e1);
        if (dis) return 32'(hwtc_pkg::TERM_OFF);
        if (m < 4'h2) return 32'(hwtc_pkg::TERM_100);
        if (m < 4'h4) return 32'(hwtc_pkg::TERM_110);
        if (m <= hwtc_pkg::MODE_E1_SYNC) return 32'(e1 ? hwtc_pkg::TERM_120 : hwtc_pkg::TERM_75);
        if (m < hwtc_pkg::MODE_6312) return 32'(hwtc_pkg::TERM_110);
        if (m == hwtc_pkg::MODE_6312) return 32'(hwtc_pkg::TERM_75);
        return 32'(hwtc_pkg::TERM_OFF);
    endfunction : exp_term

    // request held from setup until pready is seen high with penable
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        // one idle edge so a following call never re-raises psel in this time step
        @(posedge clk_in);
    endtask : apb

    // pll reference delay, pll pin equals tx clock, and no runt pulses on the tx clock
    always @(posedge clk_in) begin
        if (rst_in) begin
            since = 0;
            runlen = 0;
        end else begin
            since++;
            if (since > 4) chk(32'(pll_ref_out), 32'(hist[2]));
            if (since > 4) chk(32'(pll_clk_out), 32'(tx_clk_out));
            if (tx_clk_out !== prev && runlen > 0 && runlen < 4) chk(32'(runlen), 32'h4);
            runlen = (tx_clk_out !== prev) ? ((since > 4) ? 1 : 0) : ((runlen > 0) ? runlen + 1 : 0);
        end
        hist = {hist[1:0], src[0]};
        prev = tx_clk_out;
    end

    initial begin
        // a full run needs well under 2000 cycles
        repeat (5000) @(posedge clk_in);
        num_errors++;
        give_verdict();
    end

    initial begin
        seed = 32'hCED31E71;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, bus_if_sel_in} = '0;
        {tx_clk_src_sel_lo_in, tx_clk_src_sel_hi_in, tx_term_disable_in, rx_term_disable_in} = '0;
        {e1_term_impedance_sel_in, irq_n_pin_in, cs_n_pin_in, irq_req_in} = '0;
        {tx_mode_select_pins_in, rx_mode_select_pins_in} = '0;
        rst_in = 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(1'b1, hwtc_pkg::CTRL_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, hwtc_pkg::CTRL_ADDR, 32'h0);
        chk(rd, hwtc_pkg::CTRL_MASK);
        apb(1'b1, hwtc_pkg::STATUS_ADDR, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, err} ^ rd, 32'h1);
        // processor mode: register fields set termination, pins keep port meanings
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            irq_req_in <= d[20];
            cs_n_pin_in <= d[0];
            irq_n_pin_in <= 1'b1;
            apb(1'b1, hwtc_pkg::CTRL_ADDR, d);
            repeat (8) @(posedge clk_in);
            chk(32'(tx_term_out), exp_term(d[12:9], d[2], d[4]));
            chk(32'(rx_term_out), exp_term(d[8:5], d[3], d[4]));
            chk({jitter_att_clk_sel0_out, remote_loopback_en_out, irq_n_pin_oe_out}, {2'h0, d[20]});
            chk(32'(irq_n_pin_out), 32'h0);
            chk(32'(port_cs_n_out), 32'(d[0]));
        end
        bus_if_sel_in <= hwtc_pkg::HW_MODE_CODE;
        for (int i = 0; i < 48; i++) begin
            d = $random(seed);
            rx_mode_select_pins_in <= (i < 16) ? 4'(i) : d[3:0];
            tx_mode_select_pins_in <= (i < 16) ? 4'(15 - i) : (d[9] ? d[3:0] : d[7:4]);
            {tx_term_disable_in, rx_term_disable_in} <= (i < 16) ? 2'h0 : d[11:10];
            {e1_term_impedance_sel_in, irq_n_pin_in, cs_n_pin_in, irq_req_in} <= d[15:12];
            repeat (8) @(posedge clk_in);
            chk(32'(hw_mode_out), 32'h1);
            chk(32'(tx_term_out), exp_term(tx_mode_select_pins_in, tx_term_disable_in, d[15]));
            chk(32'(rx_term_out), exp_term(rx_mode_select_pins_in, rx_term_disable_in, d[15]));
            if (i >= 16 && d[9] && d[11] == d[10]) chk(32'(tx_term_out), 32'(rx_term_out));
            chk({jitter_att_clk_sel0_out, remote_loopback_en_out}, 32'(d[14:13]));
            chk({port_cs_n_out, irq_n_pin_oe_out}, 32'h2);
        end
        // each source has its own period, so edges in 96 cycles identify it
        for (int s = 3; s >= 0; s--) begin
            {tx_clk_src_sel_hi_in, tx_clk_src_sel_lo_in} <= 2'(s);
            repeat (60) @(posedge clk_in);
            apb(1'b0, hwtc_pkg::STATUS_ADDR, 32'h0);
            chk(rd[3:0], {1'b0, 2'(s), 1'b1});
            n = 0;
            last = tx_clk_out;
            repeat (96) begin
                @(posedge clk_in);
                if (tx_clk_out === 1'b1 && last === 1'b0) n++;
                last = tx_clk_out;
            end
            chk(32'(n), 32'(96 / (8 + 4 * s + ((s == 3) ? 4 : 0))));
        end
        give_verdict();
    end
endmodule : hwtc_top_tb
`default_nettype wire
